// >>> rtl/nat_alu.sv
/*
 Nibble ALU and ROM table-read datapath of a small microcontroller core.
 Holds accumulator, Y, X and status; reads RAM combinationally at {X,Y};
 reads program ROM with one cycle of latency. Driven by the instruction
 sequencer on the same clock, so no input is synchronised.
*/
// Function
// - Table read loads ROM byte into A,Y
// - Table read saves then restores PC, page, block
// - Add memory to A, carry to status
// - Memory minus A into A, no-borrow status
// - Memory plus one into A, carry status
// - Memory minus one into A, no-borrow status
// - Increment A, status always set
// - Increment Y, carry to status
// - Decrement A, no-borrow status
// - Decrement Y, no-borrow status
// - XOR memory into A, status set
// - Negate A, status set when zero
// - Compare A not above memory into status, A not written
// - RAM operand addressed by X page, Y word
`timescale 1ns/100ps
`default_nettype none
`include "nat_defines.svh"

module nat_alu (
   input wire logic clk,
   input wire logic reset,
   input wire logic opValid,
   input wire nat_pkg::nat_op_e opCode,
   output logic busy,
   input wire logic accLoad,
   input wire logic [`NAT_NIB_W-1:0] accLoadData,
   input wire logic idxLoad,
   input wire logic [`NAT_NIB_W-1:0] idxLoadData,
   input wire logic xLoad,
   input wire logic [`NAT_X_W-1:0] xLoadData,
   input wire logic [`NAT_PC_W-1:0] pcIn,
   input wire logic [`NAT_PAGE_W-1:0] currentPage,
   input wire logic [`NAT_BLOCK_W-1:0] currentBlock,
   output logic [`NAT_NIB_W-1:0] acc,
   output logic [`NAT_NIB_W-1:0] idx,
   output logic [`NAT_X_W-1:0] xReg,
   output logic statusFlag,
   output logic [`NAT_X_W+`NAT_NIB_W-1:0] ramAddr,
   input wire logic [`NAT_NIB_W-1:0] ramData,
   output logic [`NAT_X_W+2*`NAT_NIB_W-1:0] romAddr,
   output logic romRead,
   input wire logic [`NAT_ROM_W-1:0] romData,
   output logic restoreValid,
   output logic [`NAT_PC_W-1:0] restorePc,
   output logic [`NAT_PAGE_W-1:0] restorePage,
   output logic [`NAT_PAGE_W-1:0] restorePageBuffer,
   output logic [`NAT_BLOCK_W-1:0] restoreBlock
);
   import nat_pkg::*;

   nat_core_s q; // Registered datapath state
   nat_core_s d; // Next datapath state
   nat_stack_if stk (); // Link to the return stack

   logic [`NAT_NIB_W:0] sum; // Five-bit adder result, top bit is carry
   logic [`NAT_NIB_W-1:0] accInv; // One's complement of A

   // Return stack, kept in its own module
   nat_return_stack uStack (
      .clk(clk),
      .reset(reset),
      .stk(stk)
   );

   assign accInv = ~q.acc;

   // Next-state logic: load ports, ALU operations, table-read sequence
   always_comb begin
      d = q;
      sum = '0;
      d.romRead = 1'b0; // Pulses last one cycle
      d.restoreValid = 1'b0;
      stk.push = 1'b0;
      stk.pop = 1'b0;
      stk.pushFrame.pc = pcIn + `NAT_PC_ONE;
      stk.pushFrame.pageNum = currentPage;
      stk.pushFrame.blockNum = currentBlock;
      unique case (q.state)
         NAT_SEQ_IDLE: begin
            // Plain loads from the sequencer, only while idle
            if (accLoad) begin
               d.acc = accLoadData;
            end
            if (idxLoad) begin
               d.idx = idxLoadData;
            end
            if (xLoad) begin
               d.xReg = xLoadData;
            end
            if (opValid) begin
               unique case (opCode)
                  NAT_OP_ROM_TABLE_READ: begin
                     stk.push = 1'b1;
                     d.romAddr = {q.xReg, q.acc, q.idx};
                     d.romRead = 1'b1;
                     d.state = NAT_SEQ_FETCH;
                  end
                  NAT_OP_ADD_MEM_TO_ACC: begin
                     sum = {1'b0, ramData} + {1'b0, q.acc};
                     d.acc = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  NAT_OP_SUB_ACC_FROM_MEM: begin
                     // Two's-complement add; carry out means no borrow
                     sum = {1'b0, ramData} + {1'b0, accInv} + {1'b0, `NAT_NIB_ONE};
                     d.acc = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  NAT_OP_INC_MEM_TO_ACC: begin
                     sum = {1'b0, ramData} + {1'b0, `NAT_NIB_ONE};
                     d.acc = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  NAT_OP_DEC_MEM_TO_ACC: begin
                     sum = {1'b0, ramData} + {1'b0, `NAT_NIB_MINUS1};
                     d.acc = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  NAT_OP_INC_ACC: begin
                     sum = {1'b0, q.acc} + {1'b0, `NAT_NIB_ONE};
                     d.acc = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = `NAT_STATUS_SET;
                  end
                  NAT_OP_INC_INDEX: begin
                     sum = {1'b0, q.idx} + {1'b0, `NAT_NIB_ONE};
                     d.idx = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  NAT_OP_DEC_ACC: begin
                     sum = {1'b0, q.acc} + {1'b0, `NAT_NIB_MINUS1};
                     d.acc = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  NAT_OP_DEC_INDEX: begin
                     sum = {1'b0, q.idx} + {1'b0, `NAT_NIB_MINUS1};
                     d.idx = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  NAT_OP_XOR_MEM_ACC: begin
                     d.acc = ramData ^ q.acc;
                     d.statusFlag = `NAT_STATUS_SET;
                  end
                  NAT_OP_NEGATE_ACC: begin
                     // Carry out of ~A+1 appears only when A is zero
                     sum = {1'b0, accInv} + {1'b0, `NAT_NIB_ONE};
                     d.acc = sum[`NAT_NIB_W-1:0];
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  NAT_OP_ACC_LE_MEM_COMPARE: begin
                     // Same subtractor as the subtract, result dropped
                     sum = {1'b0, ramData} + {1'b0, accInv} + {1'b0, `NAT_NIB_ONE};
                     d.statusFlag = sum[`NAT_NIB_W];
                  end
                  default: begin
                     // Undefined code: nothing changes
                  end
               endcase
            end
         end
         NAT_SEQ_FETCH: begin
            // ROM answers one cycle after the read strobe
            d.state = NAT_SEQ_LOAD;
         end
         NAT_SEQ_LOAD: begin
            d.acc = romData[`NAT_ROM_W-1:`NAT_NIB_W];
            d.idx = romData[`NAT_NIB_W-1:0];
            d.statusFlag = `NAT_STATUS_SET;
            d.restore = stk.topFrame;
            d.restoreValid = 1'b1;
            stk.pop = 1'b1;
            d.state = NAT_SEQ_IDLE;
         end
      endcase
   end

   // State register; constants only under reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q.state <= NAT_SEQ_IDLE;
         q.acc <= `NAT_NIB_ZERO;
         q.idx <= `NAT_NIB_ZERO;
         q.xReg <= `NAT_X_ZERO;
         q.statusFlag <= `NAT_STATUS_INIT;
         q.romAddr <= '0;
         q.romRead <= 1'b0;
         q.restoreValid <= 1'b0;
         q.restore <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state record
   assign busy = (q.state != NAT_SEQ_IDLE); // Ops ignored while set
   assign acc = q.acc;
   assign idx = q.idx;
   assign xReg = q.xReg;
   assign statusFlag = q.statusFlag;
   assign ramAddr = {q.xReg, q.idx};
   assign romAddr = q.romAddr;
   assign romRead = q.romRead;
   assign restoreValid = q.restoreValid;
   assign restorePc = q.restore.pc;
   assign restorePage = q.restore.pageNum; // Page and page buffer alike
   assign restorePageBuffer = q.restore.pageNum;
   assign restoreBlock = q.restore.blockNum;

endmodule

`default_nettype wire

// >>> rtl/nat_defines.svh
/*
 Holds the named widths, reset values and arithmetic constants of the
 nibble ALU and table-read block.
 Assumes it is included by the package and the design files by its bare name.
*/
`ifndef NAT_DEFINES_SVH
`define NAT_DEFINES_SVH

// Datapath widths
`define NAT_NIB_W 4
`define NAT_X_W 2
`define NAT_ROM_W 8
`define NAT_PC_W 6
`define NAT_PAGE_W 4
`define NAT_BLOCK_W 2
`define NAT_STACK_DEPTH 3

// Constants used by the adders, and the zero reset values of A, Y and X
`define NAT_NIB_ZERO 4'h0
`define NAT_NIB_ONE 4'h1
`define NAT_NIB_MINUS1 4'hF
`define NAT_PC_ONE 6'h01
`define NAT_X_ZERO 2'h0

// Status flag value that increment A, XOR and table read leave behind, and its reset value
`define NAT_STATUS_SET 1'b1
`define NAT_STATUS_INIT 1'b1

`endif

// >>> rtl/nat_pkg.sv
/*
 Package of types for the nibble ALU and table-read block: operation
 codes, sequence states, return-stack frame and state records.
 Assumes nat_defines.svh is on the include path.
*/
`include "nat_defines.svh"

package nat_pkg;

   // Operations issued by the instruction sequencer
   typedef enum logic [3:0] {
      NAT_OP_ROM_TABLE_READ = 4'h0,
      NAT_OP_ADD_MEM_TO_ACC = 4'h1,
      NAT_OP_SUB_ACC_FROM_MEM = 4'h2,
      NAT_OP_INC_MEM_TO_ACC = 4'h3,
      NAT_OP_DEC_MEM_TO_ACC = 4'h4,
      NAT_OP_INC_ACC = 4'h5,
      NAT_OP_INC_INDEX = 4'h6,
      NAT_OP_DEC_ACC = 4'h7,
      NAT_OP_DEC_INDEX = 4'h8,
      NAT_OP_XOR_MEM_ACC = 4'h9,
      NAT_OP_NEGATE_ACC = 4'hA,
      NAT_OP_ACC_LE_MEM_COMPARE = 4'hB
   } nat_op_e;

   // Table-read sequence states, one-hot
   typedef enum logic [2:0] {
      NAT_SEQ_IDLE = 3'b001,
      NAT_SEQ_FETCH = 3'b010,
      NAT_SEQ_LOAD = 3'b100
   } nat_state_e;

   // One return-stack level: return address, page and block
   typedef struct packed {
      logic [`NAT_BLOCK_W-1:0] blockNum;
      logic [`NAT_PAGE_W-1:0] pageNum;
      logic [`NAT_PC_W-1:0] pc;
   } nat_frame_s;

   // Whole state of the return stack
   typedef struct packed {
      nat_frame_s [`NAT_STACK_DEPTH-1:0] lvl;
   } nat_stack_s;

   // Whole state of the datapath
   typedef struct packed {
      nat_state_e state;
      logic [`NAT_NIB_W-1:0] acc;
      logic [`NAT_NIB_W-1:0] idx;
      logic [`NAT_X_W-1:0] xReg;
      logic statusFlag;
      logic [`NAT_X_W+2*`NAT_NIB_W-1:0] romAddr;
      logic romRead;
      logic restoreValid;
      nat_frame_s restore;
   } nat_core_s;

endpackage

// >>> rtl/nat_stack_if.sv
/*
 Carrier between the datapath and its return stack: push and pop
 strobes, the frame pushed and the frame on top.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface nat_stack_if;
   import nat_pkg::*;
   logic push; // Shift down, new frame on top
   logic pop; // Shift up, deepest level kept
   nat_frame_s pushFrame; // Frame to save
   nat_frame_s topFrame; // Level one

   // Datapath side
   modport ctrl (output push, output pop, output pushFrame, input topFrame);
   // Stack side
   modport store (input push, input pop, input pushFrame, output topFrame);
endinterface

`default_nettype wire

// >>> rtl/nat_return_stack.sv
/*
 Three-level return, page and block stack for the table-read sequence.
 Assumes push and pop never come in the same cycle; push wins if they do.
*/
`timescale 1ns/100ps
`default_nettype none
`include "nat_defines.svh"

module nat_return_stack (
   input wire logic clk,
   input wire logic reset,
   nat_stack_if.store stk
);
   import nat_pkg::*;

   nat_stack_s q; // Registered stack
   nat_stack_s d; // Next stack

   // Shift logic; the deepest level copies itself on a pop
   always_comb begin
      d = q;
      if (stk.push) begin
         for (int i = `NAT_STACK_DEPTH - 1; i > 0; i--) begin
            d.lvl[i] = q.lvl[i-1];
         end
         d.lvl[0] = stk.pushFrame;
      end else if (stk.pop) begin
         for (int i = 0; i < `NAT_STACK_DEPTH - 1; i++) begin
            d.lvl[i] = q.lvl[i+1];
         end
      end
   end

   // State register, cleared on reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign stk.topFrame = q.lvl[0]; // Level one for the restore

endmodule

`default_nettype wire

// >>> tb/nat_alu_assertions.sv
/*
 Checker for the nibble ALU: results, status and table-read timing.
 Sees only the top ports and is attached by the bind at the foot.
*/
`timescale 1ns/100ps
`default_nettype none
module nat_alu_assertions
   import nat_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic opValid,
   input wire nat_op_e opCode,
   input wire logic busy,
   input wire logic [3:0] acc,
   input wire logic [3:0] idx,
   input wire logic [1:0] xReg,
   input wire logic statusFlag,
   input wire logic [5:0] ramAddr,
   input wire logic [3:0] ramData,
   input wire logic [9:0] romAddr,
   input wire logic romRead,
   input wire logic restoreValid,
   input wire logic [5:0] restorePc,
   input wire logic [5:0] pcIn
);
   wire go = opValid && !busy; // Request actually taken
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_ram_addr: assert property (ramAddr == {xReg, idx})
      else $error("ram address not X and Y");
   a_add_carry: assert property (go && opCode == NAT_OP_ADD_MEM_TO_ACC |=>
      {statusFlag, acc} == {1'b0, $past(ramData)} + $past(acc)) else $error("add wrong");
   a_sub_borrow: assert property (go && opCode == NAT_OP_SUB_ACC_FROM_MEM |=>
      acc == $past(ramData) - $past(acc) && statusFlag == ($past(acc) <= $past(ramData)))
      else $error("subtract wrong");
   a_inc_acc: assert property (go && opCode == NAT_OP_INC_ACC |=>
      statusFlag && acc == $past(acc) + 4'h1) else $error("acc increment wrong");
   a_dec_index: assert property (go && opCode == NAT_OP_DEC_INDEX |=>
      idx == $past(idx) + 4'hF && statusFlag == ($past(idx) != 4'h0)) else $error("Y dec wrong");
   a_negate_acc: assert property (go && opCode == NAT_OP_NEGATE_ACC |=>
      acc == ~$past(acc) + 4'h1 && statusFlag == ($past(acc) == 4'h0)) else $error("negate wrong");
   a_compare_only: assert property (go && opCode == NAT_OP_ACC_LE_MEM_COMPARE |=>
      acc == $past(acc) && statusFlag == ($past(acc) <= $past(ramData)))
      else $error("compare wrong");
   a_table_fetch: assert property (go && opCode == NAT_OP_ROM_TABLE_READ |=>
      romRead && busy && romAddr == {$past(xReg), $past(acc), $past(idx)} ##1 busy && !romRead
      ##1 restoreValid && !busy && statusFlag) else $error("table read timing wrong");
   a_table_return: assert property (go && opCode == NAT_OP_ROM_TABLE_READ |->
      ##3 restoreValid && restorePc == $past(pcIn, 3) + 6'h01) else $error("return pc wrong");
endmodule
bind nat_alu nat_alu_assertions chk (.clk, .reset, .opValid, .opCode, .busy, .acc, .idx,
   .xReg, .statusFlag, .ramAddr, .ramData, .romAddr, .romRead, .restoreValid, .restorePc, .pcIn);
`default_nettype wire

// >>> tb/nat_mem_model.sv
/*
 RAM and program ROM beside the ALU. RAM is a fixed pattern of the address;
 ROM answers one cycle after the read strobe and shows changing junk otherwise.
*/
`timescale 1ns/100ps
`default_nettype none
module nat_mem_model (
   input wire logic clk,
   input wire logic [5:0] ramAddr,
   output logic [3:0] ramData,
   input wire logic [9:0] romAddr,
   input wire logic romRead,
   output logic [7:0] romData
);
   logic fresh = 1'b0; // Byte due this cycle
   logic [7:0] last = 8'h00; // Last byte shown
   // Word is Y bent by the page, so X=0 reads back Y
   assign ramData = ramAddr[3:0] ^ {ramAddr[5:4], ramAddr[5:4]};
   // Outside its slot the byte flips, so a late sample is caught
   assign romData = fresh ? romAddr[7:0] ^ {romAddr[9:8], 6'h25} : ~last;
   always @(posedge clk) begin
      fresh <= romRead;
      last <= romData;
   end
endmodule
`default_nettype wire

// >>> tb/test_nibble_alu_and_table_read.sv
/*
 Self-checking bench for nat_alu with the memory model on its far side.
 Assumes the checker is bound in from its own file.
*/
`timescale 1ns/100ps
`default_nettype none
module test_nibble_alu_and_table_read;
   import nat_pkg::*;
   logic clk, reset, opValid, busy, accLoad, idxLoad, xLoad, statusFlag, romRead, restoreValid;
   nat_op_e opCode;
   logic [3:0] accLoadData, idxLoadData, acc, idx, ramData, currentPage, restorePage;
   logic [3:0] restorePageBuffer;
   logic [1:0] xLoadData, xReg, currentBlock, restoreBlock;
   logic [5:0] pcIn, ramAddr, restorePc;
   logic [9:0] romAddr;
   logic [7:0] romData;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   nat_alu uut (.clk, .reset, .opValid, .opCode, .busy, .accLoad, .accLoadData, .idxLoad,
      .idxLoadData, .xLoad, .xLoadData, .pcIn, .currentPage, .currentBlock, .acc, .idx, .xReg,
      .statusFlag, .ramAddr, .ramData, .romAddr, .romRead, .romData, .restoreValid,
      .restorePc, .restorePage, .restorePageBuffer, .restoreBlock);
   nat_mem_model mem (.clk, .ramAddr, .ramData, .romAddr, .romRead, .romData);
   task automatic close_out;
      $display("checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
      checks_done++;
      if (ex !== sn) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, ex, sn);
      end
   endtask
   // Load A, Y, X, issue one op, judge A, Y, status a cycle later unless it is a table read
   task automatic t(input nat_op_e op, input logic [3:0] a, y, input logic [1:0] x,
         input logic [3:0] ea, ey, input logic es);
      @(posedge clk); #2;
      {accLoad, idxLoad, xLoad} = 3'b111;
      {accLoadData, idxLoadData, xLoadData} = {a, y, x};
      @(posedge clk); #2;
      {accLoad, idxLoad, xLoad} = 3'b000;
      opValid = 1'b1;
      opCode = op;
      @(posedge clk); #2;
      opValid = 1'b0;
      if (op != NAT_OP_ROM_TABLE_READ) begin
         chk("acc", ea, acc);
         chk("idx", ey, idx);
         chk("status", es, statusFlag);
      end
   endtask
   task automatic t_reset;
      chk("acc", 8'h00, acc);
      chk("status", 8'h01, statusFlag);
      chk("busy", 8'h00, busy);
   endtask
   task automatic t_add_sub;
      t(NAT_OP_ADD_MEM_TO_ACC, 4'h9, 4'h8, 2'h0, 4'h1, 4'h8, 1'b1);
      t(NAT_OP_ADD_MEM_TO_ACC, 4'h7, 4'h8, 2'h0, 4'hF, 4'h8, 1'b0);
      t(NAT_OP_SUB_ACC_FROM_MEM, 4'h8, 4'h8, 2'h0, 4'h0, 4'h8, 1'b1);
      t(NAT_OP_SUB_ACC_FROM_MEM, 4'h9, 4'h8, 2'h0, 4'hF, 4'h8, 1'b0);
   endtask
   task automatic t_mem_step;
      t(NAT_OP_INC_MEM_TO_ACC, 4'h3, 4'hF, 2'h0, 4'h0, 4'hF, 1'b1);
      t(NAT_OP_INC_MEM_TO_ACC, 4'h3, 4'hE, 2'h0, 4'hF, 4'hE, 1'b0);
      t(NAT_OP_DEC_MEM_TO_ACC, 4'h3, 4'h1, 2'h0, 4'h0, 4'h1, 1'b1);
      t(NAT_OP_DEC_MEM_TO_ACC, 4'h3, 4'h0, 2'h0, 4'hF, 4'h0, 1'b0);
   endtask
   task automatic t_acc_idx;
      t(NAT_OP_INC_ACC, 4'hF, 4'h2, 2'h0, 4'h0, 4'h2, 1'b1);
      t(NAT_OP_DEC_ACC, 4'h0, 4'h2, 2'h0, 4'hF, 4'h2, 1'b0);
      t(NAT_OP_INC_INDEX, 4'h5, 4'hF, 2'h0, 4'h5, 4'h0, 1'b1);
      t(NAT_OP_INC_INDEX, 4'h5, 4'hE, 2'h0, 4'h5, 4'hF, 1'b0);
      t(NAT_OP_DEC_ACC, 4'h1, 4'h2, 2'h0, 4'h0, 4'h2, 1'b1);
      t(NAT_OP_DEC_INDEX, 4'h5, 4'h0, 2'h0, 4'h5, 4'hF, 1'b0);
      t(NAT_OP_DEC_INDEX, 4'h5, 4'h1, 2'h0, 4'h5, 4'h0, 1'b1);
   endtask
   task automatic t_logic;
      t(NAT_OP_XOR_MEM_ACC, 4'h5, 4'h3, 2'h1, 4'h3, 4'h3, 1'b1);
      t(NAT_OP_NEGATE_ACC, 4'h3, 4'h3, 2'h1, 4'hD, 4'h3, 1'b0);
      t(NAT_OP_NEGATE_ACC, 4'h0, 4'h3, 2'h1, 4'h0, 4'h3, 1'b1);
      t(NAT_OP_ACC_LE_MEM_COMPARE, 4'h7, 4'h3, 2'h1, 4'h7, 4'h3, 1'b0);
      t(NAT_OP_ACC_LE_MEM_COMPARE, 4'h6, 4'h3, 2'h1, 4'h6, 4'h3, 1'b1);
   endtask
   // Table read with an op tried while busy, which must be dropped
   task automatic t_table;
      {pcIn, currentPage, currentBlock} = {6'h3F, 4'h5, 2'h2};
      t(NAT_OP_ROM_TABLE_READ, 4'h3, 4'h4, 2'h2, 4'h0, 4'h0, 1'b0);
      chk("romAddr", 8'h34, romAddr[7:0]);
      chk("romAddrX", 8'h02, romAddr[9:8]);
      @(posedge clk); #2;
      opValid = 1'b1;
      opCode = NAT_OP_INC_ACC;
      {xLoad, xLoadData} = 3'b101; // Page load refused while busy
      @(posedge clk); #2;
      opValid = 1'b0;
      xLoad = 1'b0;
      chk("restoreValid", 8'h01, restoreValid);
      chk("xReg", 8'h02, xReg);
      chk("acc", 8'h09, acc);
      chk("idx", 8'h01, idx);
      chk("status", 8'h01, statusFlag);
      chk("restorePc", 8'h00, restorePc);
      chk("restorePage", 8'h05, restorePage);
      chk("restorePageBuffer", 8'h05, restorePageBuffer);
      chk("restoreBlock", 8'h02, restoreBlock);
   endtask
   // Reset in mid table read: sequence dropped, outputs back at rest
   task automatic t_mid_reset;
      t(NAT_OP_ROM_TABLE_READ, 4'h1, 4'h2, 2'h3, 4'h0, 4'h0, 1'b0);
      reset = 1'b1;
      @(posedge clk); #2;
      reset = 1'b0;
      chk("busy", 8'h00, busy);
      chk("romRead", 8'h00, romRead);
      chk("restorePage", 8'h00, restorePage);
      chk("xReg", 8'h00, xReg);
      chk("acc", 8'h00, acc);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      {reset, opValid, accLoad, idxLoad, xLoad} = 5'b10000;
      opCode = NAT_OP_INC_ACC;
      {accLoadData, idxLoadData, xLoadData} = 10'h000;
      {pcIn, currentPage, currentBlock} = 12'h000;
      repeat (4) @(posedge clk);
      #2;
      reset = 1'b0;
      t_reset();
      t_add_sub();
      t_mem_step();
      t_acc_idx();
      t_logic();
      t_table();
      t_mid_reset();
      close_out();
   end
endmodule
`default_nettype wire
